// ==== rtl/rrch_pkg.sv ====
// rrch_pkg: shared constants for the remote register command handshake.
// assumes both ends use the same word layout and one shared clock.
package rrch_pkg;
   localparam int          NUM_DRV        = 2;
   localparam int          WORDS_PER_DRV  = 4;
   // word index inside a driver's four-word group
   localparam int          W_CODE         = 0;
   localparam int          W_ADDR         = 1;
   localparam int          W_LO           = 2;
   localparam int          W_HI           = 3;
   localparam logic [15:0] CMD_NV_SAVE    = 16'h30C9;
   localparam logic [15:0] NV_SAVE_LO     = 16'h0001;
   localparam logic [15:0] NV_SAVE_HI     = 16'h0000;
   localparam logic [15:0] CMD_POS0_WRITE = 16'h1200;
   localparam logic [15:0] CMD_POS0_READ  = 16'h0200;
   localparam logic [15:0] CMD_DET_POS    = 16'h2066;
   // cycles the device spends executing one command
   localparam int          EXEC_CYCLES    = 4;
   // axi register map of the master controller
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_CMD0       = 8'h08;
   localparam logic [7:0]  REG_DATA0      = 8'h0C;
   localparam logic [7:0]  REG_CMD1       = 8'h10;
   localparam logic [7:0]  REG_DATA1      = 8'h14;
   localparam logic [7:0]  REG_RESP0_CMD  = 8'h18;
   localparam logic [7:0]  REG_RESP0_DATA = 8'h1C;
   localparam logic [7:0]  REG_RESP1_CMD  = 8'h20;
   localparam logic [7:0]  REG_RESP1_DATA = 8'h24;
   localparam logic [7:0]  REG_FIX_POS0   = 8'h28;
   localparam logic [7:0]  REG_FIX_POS1   = 8'h2C;
   // ctrl bit positions, driver 1 shifted up by eight bits
   localparam int          CTRL_CMD_GO    = 0;
   localparam int          CTRL_REVERSE   = 1;
   localparam int          CTRL_FIX_WR    = 2;
   localparam int          CTRL_FIX_RD    = 3;
   localparam int          CTRL_DRV1_OFS  = 8;
   // status bit positions, driver 1 shifted up by eight bits
   localparam int          ST_BUSY        = 0;
   localparam int          ST_MATCH       = 1;
   localparam int          ST_FIX_WACK    = 2;
   localparam int          ST_FIX_RACK    = 3;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : rrch_pkg

// ==== rtl/rrch_link_if.sv ====
// rrch_link_if: remote bits and remote words between master and converter.
// assumes one clock shared by both ends; no tristate pins.
`timescale 1ns/10ps
`default_nettype none
interface rrch_link_if;
   logic [15:0] wr_word [0:7];
   logic [15:0] rd_word [0:7];
   logic [1:0]  cmd_request;
   logic [1:0]  cmd_complete;
   logic [1:0]  reverse_continuous_run;
   logic [1:0]  fixed_write_request;
   logic [1:0]  fixed_write_ack;
   logic [1:0]  fixed_read_request;
   logic [1:0]  fixed_read_ack;
   modport device (
      input  wr_word, cmd_request, reverse_continuous_run,
             fixed_write_request, fixed_read_request,
      output rd_word, cmd_complete, fixed_write_ack, fixed_read_ack
   );
   modport master (
      output wr_word, cmd_request, reverse_continuous_run,
             fixed_write_request, fixed_read_request,
      input  rd_word, cmd_complete, fixed_write_ack, fixed_read_ack
   );
endinterface : rrch_link_if
`default_nettype wire

// ==== rtl/rrch_device.sv ====
// rrch_device: network converter end; executes commands for two drivers.
// assumes master drives link words from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rrch_device
   import rrch_pkg::*;
#(
   parameter int EXEC_LEN = EXEC_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   rrch_link_if.device      link,
   output logic [1:0]       motor_reverse_run,
   output logic [1:0]       nv_save_pulse,
   output logic [31:0]      nv_pos0_drv0,
   output logic [31:0]      nv_pos0_drv1
);
   // the execute counter is eight bits wide
   if (EXEC_LEN < 1 || EXEC_LEN > 255) begin : g_bad_len
      $error("EXEC_LEN out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } rrch_dev_state_type;

   rrch_dev_state_type state_q [NUM_DRV];
   logic [7:0]         cnt_q   [NUM_DRV];
   logic [31:0]        pos0_q  [NUM_DRV];
   logic [31:0]        det_q   [NUM_DRV];
   logic [15:0]        echo_q  [NUM_DRV][WORDS_PER_DRV];
   logic [1:0]         fwr_seen_q;

   function automatic logic [15:0] wrd(input int d, input int w);
      return link.wr_word[d*WORDS_PER_DRV + w];
   endfunction : wrd

   function automatic logic [31:0] join32(input int d);
      return {wrd(d, W_HI), wrd(d, W_LO)};
   endfunction : join32

   // last execute cycle of a command that is still requested
   function automatic logic exec_end(input int d);
      return state_q[d] == ST_EXEC && cnt_q[d] == 8'h00 && link.cmd_request[d];
   endfunction : exec_end

   for (genvar d = 0; d < NUM_DRV; d++) begin : g_drv
      // command selection handshake
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            state_q[d] <= ST_IDLE;
            cnt_q[d] <= 8'h00;
            link.cmd_complete[d] <= 1'b0;
            nv_save_pulse[d] <= 1'b0;
            for (int w = 0; w < WORDS_PER_DRV; w++) echo_q[d][w] <= 16'h0000;
         end else if (clk_en) begin
            nv_save_pulse[d] <= 1'b0;
            case (state_q[d])
               ST_IDLE: begin
                  if (link.cmd_request[d]) begin
                     state_q[d] <= ST_EXEC;
                     cnt_q[d] <= 8'(EXEC_LEN - 1);
                  end
               end
               ST_EXEC: begin
                  if (!link.cmd_request[d]) begin
                     state_q[d] <= ST_IDLE;
                  end else if (cnt_q[d] == 8'h00) begin
                     for (int w = 0; w < WORDS_PER_DRV; w++)
                        echo_q[d][w] <= wrd(d, w);
                     if (wrd(d, W_CODE) == CMD_NV_SAVE && wrd(d, W_LO) == NV_SAVE_LO
                         && wrd(d, W_HI) == NV_SAVE_HI)
                        nv_save_pulse[d] <= 1'b1;
                     link.cmd_complete[d] <= 1'b1;
                     state_q[d] <= ST_DONE;
                  end else begin
                     cnt_q[d] <= cnt_q[d] - 8'h01;
                  end
               end
               ST_DONE: begin
                  if (!link.cmd_request[d]) begin
                     link.cmd_complete[d] <= 1'b0;
                     state_q[d] <= ST_IDLE;
                  end
               end
               default: state_q[d] <= ST_IDLE;
            endcase
         end
      end

      // working memory: position entry 0 and fixed write acknowledge
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pos0_q[d] <= 32'h0000_0000;
            fwr_seen_q[d] <= 1'b0;
            link.fixed_write_ack[d] <= 1'b0;
         end else if (clk_en) begin
            fwr_seen_q[d] <= link.fixed_write_request[d];
            if (exec_end(d) && wrd(d, W_CODE) == CMD_POS0_WRITE)
               pos0_q[d] <= join32(d);
            if (link.fixed_write_request[d] && !fwr_seen_q[d]) begin
               pos0_q[d] <= join32(d);
               link.fixed_write_ack[d] <= 1'b1;
            end else if (!link.fixed_write_request[d]) begin
               link.fixed_write_ack[d] <= 1'b0;
            end
         end
      end

      // reverse continuous motion; detected position counts down
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            motor_reverse_run[d] <= 1'b0;
            det_q[d] <= 32'h0000_0000;
         end else if (clk_en) begin
            motor_reverse_run[d] <= link.reverse_continuous_run[d];
            if (motor_reverse_run[d]) det_q[d] <= det_q[d] - 32'h0000_0001;
         end
      end

      // read words: echo or monitor arrangement
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            link.fixed_read_ack[d] <= 1'b0;
            for (int w = 0; w < WORDS_PER_DRV; w++)
               link.rd_word[d*WORDS_PER_DRV + w] <= 16'h0000;
         end else if (clk_en) begin
            link.fixed_read_ack[d] <= link.fixed_read_request[d];
            if (link.fixed_read_request[d]) begin
               link.rd_word[d*WORDS_PER_DRV + W_CODE] <= det_q[d][15:0];
               link.rd_word[d*WORDS_PER_DRV + W_ADDR] <= det_q[d][31:16];
               link.rd_word[d*WORDS_PER_DRV + W_LO] <= pos0_q[d][15:0];
               link.rd_word[d*WORDS_PER_DRV + W_HI] <= pos0_q[d][31:16];
            end else if (exec_end(d)) begin
               // echo lands with the completion bit, unless a fixed read request keeps the monitor words in place
               for (int w = 0; w < WORDS_PER_DRV; w++)
                  link.rd_word[d*WORDS_PER_DRV + w] <= wrd(d, w);
            end else begin
               for (int w = 0; w < WORDS_PER_DRV; w++)
                  link.rd_word[d*WORDS_PER_DRV + w] <= echo_q[d][w];
            end
         end
      end
   end

   // non-volatile copy, taken only on a bulk save
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nv_pos0_drv0 <= 32'h0000_0000;
         nv_pos0_drv1 <= 32'h0000_0000;
      end else if (clk_en) begin
         if (nv_save_pulse[0] || nv_save_pulse[1]) begin
            nv_pos0_drv0 <= pos0_q[0];
            nv_pos0_drv1 <= pos0_q[1];
         end
      end
   end
endmodule : rrch_device
`default_nettype wire

// ==== rtl/rrch_master.sv ====
// rrch_master: master controller end, driven by software over AXI4-Lite.
// assumes the converter answers on the shared link clock.
`timescale 1ns/10ps
`default_nettype none
module rrch_master
   import rrch_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   rrch_link_if.master      link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic [31:0] ctrl_q, cmd_q [2], data_q [2], fpos_q [2];
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_have_q, w_have_q;
   logic [1:0]  match_q;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
      return o;
   endfunction : merge

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         ctrl_q <= 32'h0000_0000;
         cmd_q[0] <= 32'h0000_0000;
         cmd_q[1] <= 32'h0000_0001;
         data_q[0] <= 32'h0000_0000;
         data_q[1] <= 32'h0000_0000;
         fpos_q[0] <= 32'h0000_0000;
         fpos_q[1] <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (awaddr_q == REG_CTRL) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
            else if (awaddr_q == REG_CMD0) cmd_q[0] <= merge(cmd_q[0], wdata_q, wstrb_q);
            else if (awaddr_q == REG_DATA0) data_q[0] <= merge(data_q[0], wdata_q, wstrb_q);
            else if (awaddr_q == REG_CMD1) cmd_q[1] <= merge(cmd_q[1], wdata_q, wstrb_q);
            else if (awaddr_q == REG_DATA1) data_q[1] <= merge(data_q[1], wdata_q, wstrb_q);
            else if (awaddr_q == REG_FIX_POS0) fpos_q[0] <= merge(fpos_q[0], wdata_q, wstrb_q);
            else if (awaddr_q == REG_FIX_POS1) fpos_q[1] <= merge(fpos_q[1], wdata_q, wstrb_q);
            else if (awaddr_q != REG_STATUS && awaddr_q[7:2] > REG_FIX_POS1[7:2])
               s_axi_bresp <= RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // link drive: command words and request bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) link.wr_word[i] <= 16'h0000;
         link.cmd_request <= 2'b00;
         link.reverse_continuous_run <= 2'b00;
         link.fixed_write_request <= 2'b00;
         link.fixed_read_request <= 2'b00;
         match_q <= 2'b00;
      end else if (clk_en) begin
         for (int d = 0; d < 2; d++) begin
            if (ctrl_q[d*CTRL_DRV1_OFS + CTRL_FIX_WR]) begin
               link.wr_word[d*4 + W_CODE] <= 16'h0000;
               link.wr_word[d*4 + W_ADDR] <= 16'h0000;
               link.wr_word[d*4 + W_LO] <= fpos_q[d][15:0];
               link.wr_word[d*4 + W_HI] <= fpos_q[d][31:16];
            end else if (!link.cmd_request[d]) begin
               link.wr_word[d*4 + W_CODE] <= cmd_q[d][15:0];
               link.wr_word[d*4 + W_ADDR] <= 16'(d);
               link.wr_word[d*4 + W_LO] <= data_q[d][15:0];
               link.wr_word[d*4 + W_HI] <= data_q[d][31:16];
            end
            // request raised on the same edge as the last word load
            link.cmd_request[d] <= ctrl_q[d*CTRL_DRV1_OFS + CTRL_CMD_GO]
               && !ctrl_q[d*CTRL_DRV1_OFS + CTRL_FIX_WR] && !match_q[d];
            if (link.cmd_complete[d] && link.cmd_request[d]) begin
               match_q[d] <= link.rd_word[d*4 + W_CODE] == link.wr_word[d*4 + W_CODE]
                  && link.rd_word[d*4 + W_LO] == link.wr_word[d*4 + W_LO];
               link.cmd_request[d] <= 1'b0;
            end else if (!ctrl_q[d*CTRL_DRV1_OFS + CTRL_CMD_GO]) begin
               match_q[d] <= 1'b0;
            end
            link.reverse_continuous_run[d] <= ctrl_q[d*CTRL_DRV1_OFS + CTRL_REVERSE];
            link.fixed_write_request[d] <= ctrl_q[d*CTRL_DRV1_OFS + CTRL_FIX_WR];
            link.fixed_read_request[d] <= ctrl_q[d*CTRL_DRV1_OFS + CTRL_FIX_RD];
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == REG_CTRL) s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == REG_STATUS) s_axi_rdata <= {20'h00000,
               link.fixed_read_ack[1], link.fixed_write_ack[1], match_q[1], link.cmd_request[1],
               4'h0, link.fixed_read_ack[0], link.fixed_write_ack[0], match_q[0],
               link.cmd_request[0]};
            else if (s_axi_araddr == REG_CMD0) s_axi_rdata <= cmd_q[0];
            else if (s_axi_araddr == REG_DATA0) s_axi_rdata <= data_q[0];
            else if (s_axi_araddr == REG_CMD1) s_axi_rdata <= cmd_q[1];
            else if (s_axi_araddr == REG_DATA1) s_axi_rdata <= data_q[1];
            else if (s_axi_araddr == REG_RESP0_CMD)
               s_axi_rdata <= {link.rd_word[W_ADDR], link.rd_word[W_CODE]};
            else if (s_axi_araddr == REG_RESP0_DATA)
               s_axi_rdata <= {link.rd_word[W_HI], link.rd_word[W_LO]};
            else if (s_axi_araddr == REG_RESP1_CMD)
               s_axi_rdata <= {link.rd_word[4 + W_ADDR], link.rd_word[4 + W_CODE]};
            else if (s_axi_araddr == REG_RESP1_DATA)
               s_axi_rdata <= {link.rd_word[4 + W_HI], link.rd_word[4 + W_LO]};
            else if (s_axi_araddr == REG_FIX_POS0) s_axi_rdata <= fpos_q[0];
            else if (s_axi_araddr == REG_FIX_POS1) s_axi_rdata <= fpos_q[1];
            else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule : rrch_master
`default_nettype wire

// ==== test/rrch_chk.sv ====
// rrch_chk: timing checks on the link between master and converter ends.
// assumes one clock, synchronous active-low reset, signals taken from the link.
`timescale 1ns/10ps
`default_nettype none
module rrch_chk #(
   parameter int EXEC_LEN = 4
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [15:0] wr_word [0:7],
   input wire logic [15:0] rd_word [0:7],
   input wire logic [1:0]  cmd_request,
   input wire logic [1:0]  cmd_complete,
   input wire logic [1:0]  reverse_continuous_run,
   input wire logic [1:0]  fixed_write_request,
   input wire logic [1:0]  fixed_write_ack,
   input wire logic [1:0]  fixed_read_request,
   input wire logic [1:0]  fixed_read_ack
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles the driver 0 request has been held; saturates so it never wraps
   logic [7:0] run0_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !cmd_request[0]) begin
         run0_q <= 8'h00;
      end else if (run0_q != 8'hFF) begin
         run0_q <= run0_q + 8'h01;
      end
   end
   done_on_time_a:
      assert property (cmd_request[0] && run0_q == EXEC_LEN + 1 |-> cmd_complete[0])
      else $error("driver 0 completion late");
   no_early_done_a:
      assert property (run0_q >= 1 && run0_q <= EXEC_LEN |-> !cmd_complete[0])
      else $error("driver 0 completion early");
   done_drv1_a:
      assert property ($rose(cmd_request[1]) ##1 cmd_request[1] [*4] |=> cmd_complete[1])
      else $error("driver 1 completion missing");
   echo_drv0_a:
      assert property ($rose(cmd_complete[0]) |-> rd_word[0] == wr_word[0]
         && rd_word[1] == wr_word[1] && rd_word[2] == wr_word[2] && rd_word[3] == wr_word[3])
      else $error("driver 0 echo wrong");
   echo_drv1_a:
      assert property ($rose(cmd_complete[1]) |-> rd_word[4] == wr_word[4]
         && rd_word[5] == wr_word[5] && rd_word[6] == wr_word[6] && rd_word[7] == wr_word[7])
      else $error("driver 1 echo wrong");
   done_clears_a:
      assert property ($fell(cmd_request[0]) && cmd_complete[0] |=> !cmd_complete[0])
      else $error("completion not cleared");
   drop_after_done_a:
      assert property ($fell(cmd_request[0]) |-> $past(cmd_complete[0]))
      else $error("request dropped before completion");
   wr_ack_drv0_a:
      assert property ($rose(fixed_write_request[0]) |=> fixed_write_ack[0])
      else $error("driver 0 write ack missing");
   wr_ack_drv1_a:
      assert property ($rose(fixed_write_request[1]) |=> fixed_write_ack[1])
      else $error("driver 1 write ack missing");
   rd_ack_follow_a:
      assert property (fixed_read_ack[0] == $past(fixed_read_request[0]))
      else $error("read ack does not follow request");
   rd_refresh_a:
      assert property (fixed_read_request[0] && $rose(fixed_write_ack[0]) |->
         ##[1:2] {rd_word[3], rd_word[2]} == {wr_word[3], wr_word[2]})
      else $error("stored position not shown");
   reverse_seen_c: cover property ($rose(reverse_continuous_run[0]));
endmodule : rrch_chk
`default_nettype wire

// ==== test/remote_register_command_handshake_test.sv ====
// remote_register_command_handshake_test: master and converter joined by the link.
// assumes software access over AXI4-Lite; a 50 ns clock drives both ends.
`timescale 1ns/10ps
`default_nettype none
module remote_register_command_handshake_test;
   import rrch_pkg::*;
   logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, nv_pos0_drv0, nv_pos0_drv1, v, p;
   logic [1:0]  s_axi_bresp, s_axi_rresp, motor_reverse_run, nv_save_pulse, rd_resp;
   int          bad_count, n_checks, save_cnt [2];
   // model: working position entry 0 per driver, expected echo words
   logic [31:0] pos0 [2];
   logic [31:0] exp_q [$];
   rrch_link_if link ();
   rrch_device #(.EXEC_LEN(EXEC_CYCLES)) rrch_device_i (.aclk, .aresetn, .clk_en,
      .link(link), .motor_reverse_run, .nv_save_pulse, .nv_pos0_drv0, .nv_pos0_drv1);
   rrch_master rrch_master_i (.aclk, .aresetn, .clk_en, .link(link), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   rrch_chk #(.EXEC_LEN(EXEC_CYCLES)) rrch_chk_i (.aclk, .aresetn,
      .wr_word(link.wr_word), .rd_word(link.rd_word), .cmd_request(link.cmd_request),
      .cmd_complete(link.cmd_complete), .reverse_continuous_run(link.reverse_continuous_run),
      .fixed_write_request(link.fixed_write_request), .fixed_write_ack(link.fixed_write_ack),
      .fixed_read_request(link.fixed_read_request), .fixed_read_ack(link.fixed_read_ack));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      for (int d = 0; d < 2; d++) if (aresetn && nv_save_pulse[d] === 1'b1) save_cnt[d]++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   task automatic ran_out;
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
   endtask : ran_out
   function automatic logic [31:0] ctl(input int d, input int b);
      return 32'h1 << (b + CTRL_DRV1_OFS * d);
   endfunction : ctl
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (s_axi_bvalid !== 1'b1) ran_out();
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (s_axi_rvalid !== 1'b1) ran_out();
      d = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // which 0 watches the command request, otherwise the fixed write ack
   task automatic wait_sig(input int which, input int d, input logic val);
      int   n;
      logic s;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         s = (which == 0) ? link.cmd_request[d] : link.fixed_write_ack[d];
      end while (s !== val && n < 200);
      if (s !== val) ran_out();
   endtask : wait_sig
   task automatic run_cmd(input int d, input logic [15:0] code, input logic [31:0] data);
      logic [7:0]  ofs;
      logic [31:0] r;
      ofs = (d == 1) ? 8'h08 : 8'h00;
      axi_wr(REG_CMD0 + ofs, {16'h0000, code}, RESP_OKAY);
      axi_wr(REG_DATA0 + ofs, data, RESP_OKAY);
      axi_wr(REG_CTRL, ctl(d, CTRL_CMD_GO), RESP_OKAY);
      wait_sig(0, d, 1'b1);
      wait_sig(0, d, 1'b0);
      exp_q.push_back({16'(d), code});
      exp_q.push_back(data);
      axi_rd(REG_STATUS, r);
      chk(32'(r[ST_MATCH + CTRL_DRV1_OFS * d]), 32'h1);
      axi_rd(REG_RESP0_CMD + ofs, r);
      chk(r, exp_q.pop_front());
      axi_rd(REG_RESP0_DATA + ofs, r);
      chk(r, exp_q.pop_front());
      axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
   endtask : run_cmd
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      void'($urandom(33));
      axi_rd(REG_STATUS, v);
      chk(v, 32'h0);
      axi_rd(8'h30, v);
      chk(v, 32'h0);
      chk(32'(rd_resp), 32'(RESP_SLVERR));
      axi_wr(8'h40, 32'hA5A5A5A5, RESP_SLVERR);
      // status is read-only; a write must leave it alone
      axi_wr(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
      axi_rd(REG_STATUS, v);
      chk(v, 32'h0);
      for (int d = 0; d < 2; d++) begin
         for (int i = 0; i < 2; i++) begin
            pos0[d] = $urandom;
            run_cmd(d, CMD_POS0_WRITE, pos0[d]);
         end
      end
      chk(nv_pos0_drv0, 32'h0);
      chk(nv_pos0_drv1, 32'h0);
      run_cmd(0, CMD_NV_SAVE, {NV_SAVE_HI, NV_SAVE_LO});
      chk(32'(save_cnt[0]), 32'h1);
      chk(nv_pos0_drv0, pos0[0]);
      chk(nv_pos0_drv1, pos0[1]);
      for (int d = 0; d < 2; d++) begin
         pos0[d] = $urandom;
         axi_wr(REG_FIX_POS0 + 8'(4 * d), pos0[d], RESP_OKAY);
         axi_wr(REG_CTRL, ctl(d, CTRL_FIX_WR) | ctl(d, CTRL_FIX_RD), RESP_OKAY);
         wait_sig(1, d, 1'b1);
         repeat (3) @(posedge aclk);
         chk({link.rd_word[4 * d + 3], link.rd_word[4 * d + 2]}, pos0[d]);
         chk(32'(link.fixed_read_ack[d]), 32'h1);
         axi_wr(REG_CTRL, ctl(d, CTRL_REVERSE) | ctl(d, CTRL_FIX_RD), RESP_OKAY);
         repeat (4) @(posedge aclk);
         p = {link.rd_word[4 * d + 1], link.rd_word[4 * d]};
         repeat (10) @(posedge aclk);
         chk(p - {link.rd_word[4 * d + 1], link.rd_word[4 * d]}, 32'd10);
         chk(32'(motor_reverse_run[d]), 32'h1);
         // clock enable low must freeze the running position count
         clk_en <= 1'b0;
         @(posedge aclk);
         p = {link.rd_word[4 * d + 1], link.rd_word[4 * d]};
         repeat (10) @(posedge aclk);
         chk({link.rd_word[4 * d + 1], link.rd_word[4 * d]}, p);
         clk_en <= 1'b1;
         axi_wr(REG_CTRL, ctl(d, CTRL_FIX_RD), RESP_OKAY);
         repeat (4) @(posedge aclk);
         p = {link.rd_word[4 * d + 1], link.rd_word[4 * d]};
         repeat (10) @(posedge aclk);
         chk({link.rd_word[4 * d + 1], link.rd_word[4 * d]}, p);
         chk(32'(motor_reverse_run[d]), 32'h0);
         axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
      end
      report_and_stop();
   end
endmodule : remote_register_command_handshake_test
`default_nettype wire
